/* hw/dio_params.svh */
// Register map, field positions and reset values of the digital I/O router
`ifndef DIO_PARAMS_SVH
`define DIO_PARAMS_SVH

// Word indices (byte address = 4 * index)
`define DIO_IDX_STATE 6'h00
`define DIO_IDX_CTRL 6'h01
`define DIO_IDX_INV 6'h02
`define DIO_IDX_ROUTE0 6'h03
`define DIO_IDX_ROUTE7 6'h0a
`define DIO_IDX_BOE 6'h0b
`define DIO_IDX_BIN 6'h0c
`define DIO_IDX_BOUT 6'h0d

// Control word fields
`define DIO_POL_BIT 0
`define DIO_DIR_LSB 1
`define DIO_RUNM_LSB 4
`define DIO_AUXM_LSB 6
`define DIO_SINV_BIT 8

// Invert word fields
`define DIO_INV_RELAY 6
`define DIO_INV_SUPPLY 7

// Route slots
`define DIO_RT_RUN 3
`define DIO_RT_AUX 4
`define DIO_RT_SENSE 5
`define DIO_RT_RELAY 6
`define DIO_RT_SUPPLY 7

// Reset values and route maximum
`define DIO_CTRL_RST 9'h00b
`define DIO_INV_RST 8'h80
`define DIO_IN4_RST 16'h2731
`define DIO_RELAY_RST 16'h0bbf
`define DIO_ROUTE_MAX 16'hea5f

`endif

/* hw/dio_pkg.sv */
// Types of the digital I/O router
package dio_pkg;
   typedef enum logic [1:0] {
      dio_pass = 2'h0,
      dio_invert = 2'h1,
      dio_toggle = 2'h2
   } dio_mode_type;

   typedef struct packed {
      logic [8:0] ctrl;
      logic [7:0] inv;
      logic [7:0][15:0] route;
      logic [15:0] boe;
      logic [15:0] bout;
      logic [2:0] gio_out;
      logic relay;
      logic supply;
      logic drive_en;
      logic [5:0] dval;
      logic [13:0] state;
      logic run_prev;
      logic aux_prev;
      logic run_tog;
      logic aux_tog;
      logic wr_pend;
      logic [5:0] wr_idx;
      logic [31:0] hrdata;
   } dio_state_type;
endpackage

/* hw/dio_routing.sv */
// Digital I/O conditioning, keypad merge, routing and enable gating
// What this block does
// - Positive polarity reports low terminal as 0 and high as 1.
// - Polarity 0 inverts reported state of channels 1 to 6 only.
// - Bidirectional channel state shows terminal level as input or output.
// - Bulk-driven output ignores route source and inversion; state still shown.
// - Each keypad button state is the OR across connected keypads.
// - With no keypad connected all button states read 0.
// - Drive enabled only while both safe torque off channels high.
// - Safe torque off states are levels after slot 3 safety break gating, no polarity applied.
// - Without slot 3 safety module both channels pass straight through.
// - Direction bit 1 is output, 0 input; resets 1, 0, 1.
// - Run and aux button modes: pass, invert, toggle; reset pass.
// - Supply sense has an invert bit, reset 0, before routing.
// - Run, aux, sense routable to destinations 0 to 59999, reset 0.
// - Inputs 4 to 6 routable; input 4 resets to 10033, others 0.
// - Read-only bulk input word; bulk enable and value reset zero.
// - Invert 0 passes, 1 inverts, channels 1 to 6 and relay.
// - Packed state word bits 0 to 8: channels, relay, supply, sto1.
//
// The placing of the registers and the AHB-Lite register port were chosen for this implementation.
`timescale 1ns/1ns
`include "dio_params.svh"

module dio_routing (
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   input wire logic [2:0] gio_in,
   output logic [2:0] gio_out,
   output logic [2:0] gio_oe,
   input wire logic [2:0] din,
   output logic relay_out,
   output logic supply_out,
   input wire logic [3:0] kp_present,
   input wire logic [3:0] kp_run,
   input wire logic [3:0] kp_aux,
   input wire logic [3:0] kp_stop,
   input wire logic supply_sense_in,
   input wire logic sto1_in,
   input wire logic sto2_in,
   input wire logic slot3_safety_fitted,
   input wire logic [1:0] safety_break,
   output logic drive_enable,
   input wire logic [2:0] chan_src_val,
   input wire logic relay_src_val,
   input wire logic supply_src_val,
   output logic [5:0][15:0] dest_num,
   output logic [5:0] dest_active,
   output logic [5:0] dest_val,
   output logic [15:0] relay_src_num,
   output logic [15:0] supply_src_num
);
   import dio_pkg::*;

   dio_state_type r;
   dio_state_type n;

   logic [5:0] lvl;
   logic [5:0] st6;
   logic [2:0] ch_drv;
   logic run_or;
   logic aux_or;
   logic stop_or;
   logic sense;
   logic run_v;
   logic aux_v;
   logic p1;
   logic p2;
   logic [1:0] run_m;
   logic [1:0] aux_m;
   logic [3:0] ri;
   logic [5:0] ra;

   function automatic logic [31:0] rd(input dio_state_type s, input logic [5:0] idx);
      logic [31:0] v;
      logic [3:0] k;
      v = 32'h0000_0000;
      k = 4'(idx - `DIO_IDX_ROUTE0);
      case (idx)
         `DIO_IDX_STATE: v = {18'h0, s.state};
         `DIO_IDX_CTRL: v = {23'h0, s.ctrl};
         `DIO_IDX_INV: v = {24'h0, s.inv};
         `DIO_IDX_BOE: v = {16'h0, s.boe};
         `DIO_IDX_BIN: v = {26'h0, s.state[5:0]};
         `DIO_IDX_BOUT: v = {16'h0, s.bout};
         default: begin
            if (idx >= `DIO_IDX_ROUTE0 && idx <= `DIO_IDX_ROUTE7) begin
               v = {16'h0, s.route[k[2:0]]};
            end
         end
      endcase
      return v;
   endfunction

   always_comb begin
      n = r;
      lvl = {din, gio_in};
      st6 = r.ctrl[`DIO_POL_BIT] ? lvl : ~lvl;

      // Output drive of channels 1 to 3
      for (int i = 0; i < 3; i++) begin
         if (r.boe[i]) begin
            ch_drv[i] = r.bout[i];
         end else begin
            ch_drv[i] = chan_src_val[i] ^ r.inv[i];
         end
      end
      n.gio_out = ch_drv;

      n.relay = ((r.route[`DIO_RT_RELAY] != 16'h0000) & relay_src_val)
         ^ r.inv[`DIO_INV_RELAY];
      n.supply = ((r.route[`DIO_RT_SUPPLY] != 16'h0000) & supply_src_val)
         ^ r.inv[`DIO_INV_SUPPLY];

      run_or = |(kp_run & kp_present);
      aux_or = |(kp_aux & kp_present);
      stop_or = |(kp_stop & kp_present);
      sense = supply_sense_in ^ r.ctrl[`DIO_SINV_BIT];

      run_m = r.ctrl[`DIO_RUNM_LSB +: 2];
      aux_m = r.ctrl[`DIO_AUXM_LSB +: 2];
      n.run_prev = run_or;
      n.aux_prev = aux_or;
      if (run_m == dio_toggle && run_or && !r.run_prev) begin
         n.run_tog = ~r.run_tog;
      end
      if (aux_m == dio_toggle && aux_or && !r.aux_prev) begin
         n.aux_tog = ~r.aux_tog;
      end
      case (run_m)
         dio_pass: run_v = run_or;
         dio_invert: run_v = ~run_or;
         dio_toggle: run_v = r.run_tog;
         default: run_v = run_or;
      endcase
      case (aux_m)
         dio_pass: aux_v = aux_or;
         dio_invert: aux_v = ~aux_or;
         dio_toggle: aux_v = r.aux_tog;
         default: aux_v = aux_or;
      endcase

      n.dval[2:0] = st6[5:3] ^ r.inv[5:3];
      n.dval[3] = run_v;
      n.dval[4] = aux_v;
      n.dval[5] = sense;

      p1 = sto1_in & ~(slot3_safety_fitted & safety_break[0]);
      p2 = sto2_in & ~(slot3_safety_fitted & safety_break[1]);
      n.drive_en = p1 & p2;

      n.state = {stop_or, sense, aux_or, run_or, p2, p1, r.supply, r.relay, st6};

      // Bus write in data phase
      ri = 4'(r.wr_idx - `DIO_IDX_ROUTE0);
      if (r.wr_pend) begin
         case (r.wr_idx)
            `DIO_IDX_CTRL: n.ctrl = hwdata[8:0];
            `DIO_IDX_INV: n.inv = hwdata[7:0];
            `DIO_IDX_BOE: n.boe = hwdata[15:0];
            `DIO_IDX_BOUT: n.bout = hwdata[15:0];
            default: begin
               if (r.wr_idx >= `DIO_IDX_ROUTE0 && r.wr_idx <= `DIO_IDX_ROUTE7
                  && hwdata[15:0] <= `DIO_ROUTE_MAX) begin
                  n.route[ri[2:0]] = hwdata[15:0];
               end
            end
         endcase
      end

      // Address phase: capture write, fetch read data
      ra = haddr[7:2];
      n.wr_pend = hsel & htrans[1] & hready & hwrite;
      n.wr_idx = ra;
      n.hrdata = 32'h0000_0000;
      if (hsel && htrans[1] && hready && !hwrite && haddr[31:8] == 24'h0) begin
         n.hrdata = rd(r, ra);
      end
      if (haddr[31:8] != 24'h0) begin
         n.wr_pend = 1'b0;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         r <= '0;
         r.ctrl <= `DIO_CTRL_RST;
         r.inv <= `DIO_INV_RST;
         r.route[0] <= `DIO_IN4_RST;
         r.route[`DIO_RT_RELAY] <= `DIO_RELAY_RST;
      end else begin
         r <= n;
      end
   end

   // Single-cycle slave, always OKAY
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign hrdata = r.hrdata;

   assign gio_out = r.gio_out;
   assign gio_oe = r.ctrl[`DIO_DIR_LSB +: 3];
   assign relay_out = r.relay;
   assign supply_out = r.supply;
   assign drive_enable = r.drive_en;

   assign dest_num = r.route[5:0];
   assign dest_val = r.dval;
   always_comb begin
      for (int k = 0; k < 6; k++) begin
         dest_active[k] = r.route[k] != 16'h0000;
      end
   end
   assign relay_src_num = r.route[`DIO_RT_RELAY];
   assign supply_src_num = r.route[`DIO_RT_SUPPLY];
endmodule // dio_routing

/* verification/dio_far_side.sv */
// Terminal pads and slot 3 safety module model
`timescale 1ns/1ns
module dio_far_side (
   input wire logic [2:0] gio_out,
   input wire logic [2:0] gio_oe,
   input wire logic [2:0] ext_level,
   input wire logic fitted,
   input wire logic [1:0] brk_cmd,
   output logic [2:0] gio_in,
   output logic [1:0] safety_break
);
   assign gio_in = (gio_oe & gio_out) | (~gio_oe & ext_level);
   // path breaking
   // Empty slot floats high so a router that ignores fitted is caught
   assign safety_break = fitted ? brk_cmd : 2'h3;
endmodule // dio_far_side

/* verification/dio_routing_properties.sv */
// Port-level assertions of the digital I/O router
`timescale 1ns/1ns
module dio_routing_properties (
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic hsel,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic hreadyout,
   input wire logic hresp,
   input wire logic [31:0] hrdata,
   input wire logic [2:0] gio_oe,
   input wire logic sto1_in,
   input wire logic sto2_in,
   input wire logic slot3_safety_fitted,
   input wire logic [1:0] safety_break,
   input wire logic drive_enable,
   input wire logic supply_out,
   input wire logic [5:0][15:0] dest_num,
   input wire logic [5:0] dest_active,
   input wire logic [15:0] relay_src_num,
   input wire logic [15:0] supply_src_num
);
   logic [5:0] nz;
   logic [5:0] big;
   always_comb begin
      for (int i = 0; i < 6; i++) begin
         nz[i] = dest_num[i] != 16'h0;
         big[i] = dest_num[i] > 16'hea5f;
      end
   end
   default clocking @(posedge sys_clk); endclocking
   default disable iff (rst);
   enable_gate_a: assert property (!$past(rst) |-> drive_enable == $past(sto1_in && sto2_in
      && !(slot3_safety_fitted && |safety_break))) else $error("enable gating wrong");
   oe_reset_a: assert property ($fell(rst) |-> gio_oe == 3'h5)
      else $error("direction reset wrong");
   route_reset_a: assert property ($fell(rst) |-> dest_num[0] == 16'h2731 && nz[5:1] == 5'h0
      && relay_src_num == 16'h0bbf && supply_src_num == 16'h0) else $error("route reset wrong");
   supply_default_a: assert property ($fell(rst) |=> supply_out)
      else $error("supply output not inverted");
   bus_okay_a: assert property (hreadyout && !hresp)
      else $error("bus not ready or not okay");
   read_idle_a: assert property (!$past(hsel && htrans[1] && !hwrite) |-> hrdata == 32'h0)
      else $error("read data outside data phase");
   active_flag_a: assert property (dest_active == nz)
      else $error("destination active flag wrong");
   route_range_a: assert property (big == 6'h0)
      else $error("destination out of range");
endmodule // dio_routing_properties

bind dio_routing dio_routing_properties u_dio_routing_properties (.sys_clk, .rst, .hsel,
   .htrans, .hwrite, .hreadyout, .hresp, .hrdata, .gio_oe, .sto1_in, .sto2_in,
   .slot3_safety_fitted, .safety_break, .drive_enable, .supply_out, .dest_num,
   .dest_active, .relay_src_num, .supply_src_num);

/* verification/dio_routing_tb_top.sv */
// Bus-driven tests of the digital I/O router
`timescale 1ns/1ns
module dio_routing_tb_top;
   `define CK(n, e, s) begin checks++; if ((s) !== (e)) begin failures++; \
      $display("mismatch %s exp %h got %h", n, e, s); end end
   logic sys_clk, hreadyout, hresp, relay_out, supply_out, drive_enable;
   logic rst = 1'b1, hsel = 1'b0, hwrite = 1'b0, supply_sense_in = 1'b0;
   logic sto1_in = 1'b1, sto2_in = 1'b1, slot3_safety_fitted = 1'b0;
   logic relay_src_val = 1'b0, supply_src_val = 1'b0;
   logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, v;
   logic [1:0] htrans = 2'h0, safety_break, brk = 2'h3;
   logic [2:0] gio_in, gio_out, gio_oe, din = 3'h5, ext = 3'h2, chan_src_val = 3'h0;
   logic [3:0] kp_present = 4'h0, kp_run = 4'h0, kp_aux = 4'h0, kp_stop = 4'h0;
   logic [5:0][15:0] dest_num;
   logic [5:0] dest_active, dest_val;
   logic [15:0] relay_src_num, supply_src_num;
   int failures = 0, checks = 0;
   logic [31:0] ra [8] = '{32'h4, 32'h8, 32'hc, 32'h24, 32'h2c, 32'h34, 32'h28, 32'h40};
   logic [15:0] re [8] = '{16'h00b, 16'h80, 16'h2731, 16'h0bbf, 16'h0, 16'h0, 16'h0, 16'h0};
   dio_routing u_dio_routing (.sys_clk, .rst, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2),
      .hwdata, .hready(hreadyout), .hreadyout, .hresp, .hrdata, .gio_in, .gio_out, .gio_oe,
      .din, .relay_out, .supply_out, .kp_present, .kp_run, .kp_aux, .kp_stop,
      .supply_sense_in, .sto1_in, .sto2_in, .slot3_safety_fitted, .safety_break,
      .drive_enable, .chan_src_val, .relay_src_val, .supply_src_val, .dest_num,
      .dest_active, .dest_val, .relay_src_num, .supply_src_num);
   dio_far_side u_dio_far_side (.gio_out, .gio_oe, .ext_level(ext),
      .fitted(slot3_safety_fitted), .brk_cmd(brk), .gio_in, .safety_break);
   initial begin
      sys_clk = 1'b0;
      forever #4 sys_clk = ~sys_clk;
   end
   task finish_test;
      $display("checks %0d failures %0d", checks, failures);
      if (failures == 0 && checks > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   task tick(input int n);
      repeat (n) @(posedge sys_clk);
   endtask
   // Bounded wait for the slave's ready
   task hold;
      int n;
      n = 0;
      do begin
         @(posedge sys_clk);
         n++;
      end while (hreadyout !== 1'b1 && n < 16);
      if (hreadyout !== 1'b1) begin
         failures++;
         finish_test;
      end
   endtask
   // Idle edge first so a read never hits the write hazard
   task bus(input logic w, input logic [31:0] a, input logic [31:0] d);
      @(posedge sys_clk);
      hsel <= 1'b1;
      htrans <= 2'h2;
      hwrite <= w;
      haddr <= a;
      hold;
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      hold;
      v = hrdata;
   endtask
   initial begin
      tick(5);
      rst <= 1'b0;
      for (int i = 0; i < 8; i++) begin
         bus(1'b0, ra[i], 32'h0);
         `CK("reset", {16'h0, re[i]}, v)
      end
      bus(1'b0, 32'h0, 32'h0);
      `CK("levels", 6'h2a, v[5:0])
      `CK("outs", 4'he, v[9:6])
      bus(1'b0, 32'h30, 32'h0);
      `CK("bulk_in", 6'h2a, v[5:0])
      bus(1'b1, 32'h4, 32'h00a);
      bus(1'b0, 32'h0, 32'h0);
      `CK("negative", 6'h15, v[5:0])
      `CK("sto_pol", 2'h3, v[9:8])
      sto2_in <= 1'b0;
      bus(1'b0, 32'h0, 32'h0);
      `CK("sto2", 2'h1, v[9:8])
      `CK("en_off", 1'b0, drive_enable)
      sto2_in <= 1'b1;
      slot3_safety_fitted <= 1'b1;
      brk <= 2'h1;
      bus(1'b0, 32'h0, 32'h0);
      `CK("break", 2'h2, v[9:8])
      `CK("en_brk", 1'b0, drive_enable)
      brk <= 2'h0;
      tick(2);
      `CK("en_on", 1'b1, drive_enable)
      kp_present <= 4'h3;
      kp_run <= 4'h2;
      kp_aux <= 4'h1;
      kp_stop <= 4'h8;
      bus(1'b1, 32'h4, 32'h10a);
      bus(1'b0, 32'h0, 32'h0);
      `CK("keys", 4'h7, v[13:10])
      kp_present <= 4'h0;
      bus(1'b0, 32'h0, 32'h0);
      `CK("no_keys", 4'h4, v[13:10])
      bus(1'b1, 32'h18, 32'hea60);
      bus(1'b0, 32'h18, 32'h0);
      `CK("over", 32'h0, v)
      bus(1'b1, 32'h18, 32'hea5f);
      bus(1'b0, 32'h18, 32'h0);
      `CK("max", 32'hea5f, v)
      kp_present <= 4'h1;
      kp_run <= 4'h0;
      for (int m = 0; m < 2; m++) begin
         bus(1'b1, 32'h4, 32'h00b | 32'(m << 4) | 32'(m << 6));
         tick(3);
         `CK("mode", m[0], dest_val[3])
         `CK("aux_mode", 1'(m == 0), dest_val[4])
      end
      bus(1'b1, 32'h4, 32'h02b);
      for (int i = 0; i < 2; i++) begin
         kp_run <= 4'h1;
         tick(4);
         kp_run <= 4'h0;
         tick(4);
         `CK("toggle", 1'(i == 0), dest_val[3])
      end
      bus(1'b1, 32'h18, 32'h0);
      tick(1);
      `CK("unrouted", 1'b0, dest_active[3])
      `CK("in4", 1'b1, dest_val[0])
      bus(1'b1, 32'h8, 32'h88);
      tick(3);
      `CK("in4_inv", 1'b0, dest_val[0])
      bus(1'b1, 32'h8, 32'h81);
      bus(1'b1, 32'h2c, 32'h1);
      tick(3);
      `CK("bulk_out", 1'b0, gio_out[0])
      bus(1'b0, 32'h0, 32'h0);
      `CK("bulk_st", 1'b0, v[0])
      // Supply source is unrouted, so its value must not leak through
      chan_src_val <= 3'h4;
      relay_src_val <= 1'b1;
      supply_src_val <= 1'b1;
      tick(3);
      `CK("routed_out", 3'h4, gio_out)
      `CK("oe", 3'h5, gio_oe)
      `CK("relay", 1'b1, relay_out)
      `CK("supply", 1'b1, supply_out)
      finish_test;
   end
endmodule // dio_routing_tb_top
